// File: rtl/line_pin_map.svh
// Constants for the per-port line-side pin interface.
// Assumes inclusion by the design file and the bench; definitions only.
`ifndef LINE_PIN_MAP_SVH
`define LINE_PIN_MAP_SVH
`define TX_SEL_LINE_OUT  3'h0
`define TX_SEL_TX_OUT    3'h1
`define TX_SEL_TX_IN     3'h2
`define TX_SEL_RX_LINE   3'h3
`define TX_SEL_RX_OUT    3'h4
`define RX_SEL_LINE      1'h0
`define RX_SEL_OUT       1'h1
`define MASK_DELAY       2'h3
`define CFG_RST_VAL      1'h0
`define VIOL_RST_VAL     16'h0000
`define VIOL_INC         16'h0001
`define ADDR_CFG         12'h000
`define ADDR_STAT        12'h004
`define ADDR_VIOL        12'h008
`define CFG_BIT_UNIPOLAR 0
`define CFG_BIT_MASK     1
`define CFG_BIT_LOOP     2
`define CFG_BIT_TXINV    3
`define CFG_BIT_RXINV    4
`define CFG_BIT_TXPOL    5
`define CFG_BIT_RXPOL    6
`define CFG_BIT_RXSEL    7
`define CFG_LSB_TXSEL    8
`define CFG_MSB_TXSEL    10
`endif

// File: rtl/line_pin_pkg.sv
// Types shared by the line-side pin interface.
// Assumes nothing of its surroundings.
package line_pin_pkg;
  typedef struct packed {
    logic [2:0] tx_sel;
    logic       rx_sel;
    logic       rx_pol;
    logic       tx_pol;
    logic       rx_inv;
    logic       tx_inv;
    logic       loopback;
    logic       overhead_mask_mode;
    logic       unipolar_mode;
  } port_cfg_t;
  typedef struct packed {
    logic pos;
    logic neg;
  } rails_t;
  typedef enum logic [2:0] {
    BUS_IDLE  = 3'b001,
    BUS_WRITE = 3'b010,
    BUS_READ  = 3'b100
  } bus_state_t;
endpackage

// File: rtl/line_pin_if.sv
// One port of the line-side pin interface with an AHB-Lite register slave.
// Assumes all line pins and clocks are asynchronous to i_clk (100 MHz) and
// that line clocks are well below half of i_clk, so edges are found by sampling.
//
// How it works
// - Bipolar modes without mask mode drive negative rail high for negative pulse.
// - Transmit outputs update on rising edge of reference, falling if inverted.
// - Transmit reference defaults to line clock out; four others are selectable.
// - Negative-rail / mask output pin has configurable polarity inversion.
// - Mask mode outputs mask input delayed three clocks, receive mask in loopback.
// - High mask marks transmit bit invalid and overwritable; low marks valid payload.
// - Receive line clock clocks receive pins unless receive clock out is selected, and may reference transmit outputs.
// - Receive inputs sampled on rising reference edge, falling if inverted.
// - Unipolar or mask mode takes un-encoded receive data on positive rail pin.
// - Unipolar or mask mode presents un-encoded transmit data on positive rail.
// - Unipolar without mask mode counts violations each clock violation input high.
// - Mask mode drops receive data bits while receive mask input is high.
`timescale 1ns/1ns
`include "line_pin_map.svh"
module line_pin_if #(
  parameter int VIOL_W = 16
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // AHB-Lite slave
  input  wire logic        i_hsel,
  input  wire logic [11:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic      [31:0] o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  // Clock pins, sampled
  input  wire logic        i_tx_line_clock_out,
  input  wire logic        i_tx_clock_out,
  input  wire logic        i_tx_clock_in,
  input  wire logic        i_rx_line_clock,
  input  wire logic        i_rx_clock_out,
  // Transmit side from the framer
  input  wire logic        i_tx_serial_data,
  input  wire logic        i_tx_neg_data,
  input  wire logic        i_tx_overhead_mask_in,
  output logic             o_tx_pos_rail,
  output logic             o_tx_neg_rail,
  // Receive side toward the framer
  input  wire logic        i_rx_pos_rail,
  input  wire logic        i_rx_neg_rail,
  output logic             o_rx_serial_data,
  output logic             o_rx_neg_data,
  output logic             o_rx_data_valid
);

  localparam int NSYNC = 10;

  // Two-stage synchronisers for every asynchronous pin
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] meta_r;
  logic [NSYNC-1:0] sync_r;
  logic [NSYNC-1:0] sync_nxt;
  logic [NSYNC-1:0] meta_nxt;
  assign pin_raw = {i_tx_line_clock_out, i_tx_clock_out, i_tx_clock_in, i_rx_line_clock,
                    i_rx_clock_out, i_tx_serial_data, i_tx_neg_data, i_tx_overhead_mask_in,
                    i_rx_pos_rail, i_rx_neg_rail};
  always_comb begin
    meta_nxt = pin_raw;
    sync_nxt = meta_r;
  end
  always_ff @(posedge i_clk) begin
    meta_r <= meta_nxt;
    sync_r <= sync_nxt;
  end

  logic s_tx_line_clk, s_tx_clk_out, s_tx_clk_in, s_rx_line_clk, s_rx_clk_out;
  logic s_tx_data, s_tx_neg, s_tx_mask, s_rx_pos, s_rx_neg;
  assign {s_tx_line_clk, s_tx_clk_out, s_tx_clk_in, s_rx_line_clk, s_rx_clk_out,
          s_tx_data, s_tx_neg, s_tx_mask, s_rx_pos, s_rx_neg} = sync_r;

  // Configuration and counter state
  line_pin_pkg::port_cfg_t  cfg_r, cfg_nxt;
  logic [VIOL_W-1:0]        viol_r, viol_nxt;
  line_pin_pkg::bus_state_t bst_r, bst_nxt;
  logic [11:0]              addr_r, addr_nxt;
  logic [31:0]              rdata_nxt;
  // Bus handshake kept in flops so every output leaves a register
  logic                     hrdy_r, hresp_r;

  // Reference clock choice and edge detect; previous level held in prev_r
  logic tx_ref, rx_ref, tx_prev_r, rx_prev_r, tx_edge, rx_edge;
  always_comb begin
    case (cfg_r.tx_sel)
      `TX_SEL_TX_OUT:  tx_ref = s_tx_clk_out;
      `TX_SEL_TX_IN:   tx_ref = s_tx_clk_in;
      `TX_SEL_RX_LINE: tx_ref = s_rx_line_clk;
      `TX_SEL_RX_OUT:  tx_ref = s_rx_clk_out;
      default:         tx_ref = s_tx_line_clk;
    endcase
    rx_ref = (cfg_r.rx_sel == `RX_SEL_OUT) ? s_rx_clk_out : s_rx_line_clk;
    // Inversion turns the falling edge into the active one
    tx_edge = cfg_r.tx_inv ? (tx_prev_r & ~tx_ref) : (~tx_prev_r & tx_ref);
    rx_edge = cfg_r.rx_inv ? (rx_prev_r & ~rx_ref) : (~rx_prev_r & rx_ref);
  end

  // Transmit path: three-stage mask delay and rail multiplexing
  logic [2:0] mask_dly_r, mask_dly_nxt;
  logic       txp_r, txp_nxt, txn_r, txn_nxt;
  logic       mask_src;
  always_comb begin
    // Loopback takes the receive mask so external framing lines up with it
    mask_src     = cfg_r.loopback ? s_rx_neg : s_tx_mask;
    mask_dly_nxt = mask_dly_r;
    txp_nxt      = txp_r;
    txn_nxt      = txn_r;
    if (tx_edge) begin
      mask_dly_nxt = {mask_dly_r[1:0], mask_src};
      txp_nxt      = s_tx_data ^ cfg_r.tx_pol;
      if (cfg_r.overhead_mask_mode) begin
        // High marks the bit as free for outside framing
        txn_nxt = mask_dly_r[`MASK_DELAY-1] ^ cfg_r.tx_pol;
      end else if (cfg_r.unipolar_mode) begin
        txn_nxt = cfg_r.tx_pol; // Unused in unipolar, held inactive
      end else begin
        txn_nxt = s_tx_neg ^ cfg_r.tx_pol;
      end
    end
  end

  // Receive path: sample on the active edge, filter overhead
  // Data and clock pass equal synchroniser depth, so the sampled bit lines up
  logic rxd_r, rxd_nxt, rxn_r, rxn_nxt, rval_r, rval_nxt, rxp_i, rxn_i;
  always_comb begin
    rxp_i    = s_rx_pos ^ cfg_r.rx_pol;
    rxn_i    = s_rx_neg ^ cfg_r.rx_pol;
    rxd_nxt  = rxd_r;
    rxn_nxt  = rxn_r;
    rval_nxt = 1'b0;
    viol_nxt = viol_r;
    if (rx_edge) begin
      rxd_nxt = rxp_i;
      rxn_nxt = (cfg_r.unipolar_mode | cfg_r.overhead_mask_mode) ? 1'b0 : rxn_i;
      // Overhead bits never reach the framer
      rval_nxt = ~(cfg_r.overhead_mask_mode & rxn_i);
      if (cfg_r.unipolar_mode && !cfg_r.overhead_mask_mode && rxn_i) begin
        viol_nxt = viol_r + VIOL_W'(`VIOL_INC); // Wraps at full scale
      end
    end
  end

  // AHB-Lite slave: zero wait states, always OKAY
  // Read data is chosen in the address phase and stands through the data phase
  always_comb begin
    bst_nxt   = bst_r;
    addr_nxt  = addr_r;
    cfg_nxt   = cfg_r;
    rdata_nxt = o_hrdata;
    if (bst_r == line_pin_pkg::BUS_WRITE) begin
      if (addr_r == `ADDR_CFG) begin
        cfg_nxt = line_pin_pkg::port_cfg_t'(i_hwdata[`CFG_MSB_TXSEL:0]);
      end
    end
    if (i_hsel && i_hready && i_htrans[1]) begin
      addr_nxt = i_haddr;
      bst_nxt  = i_hwrite ? line_pin_pkg::BUS_WRITE : line_pin_pkg::BUS_READ;
      if (!i_hwrite) begin
        if (i_haddr == `ADDR_CFG) begin
          rdata_nxt = {21'h000000, cfg_r};
        end else if (i_haddr == `ADDR_STAT) begin
          rdata_nxt = {29'h00000000, rx_ref, tx_ref, mask_dly_r[`MASK_DELAY-1]};
        end else if (i_haddr == `ADDR_VIOL) begin
          rdata_nxt = 32'(viol_r);
        end else begin
          rdata_nxt = 32'h00000000;
        end
      end
    end else if (i_hready) begin
      bst_nxt = line_pin_pkg::BUS_IDLE;
    end
  end

  // State registers; reset forces the default reference and bipolar mode
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cfg_r       <= '0;
      viol_r      <= '0;
      bst_r       <= line_pin_pkg::BUS_IDLE;
      addr_r      <= 12'h000;
      o_hrdata    <= 32'h00000000;
      hrdy_r      <= 1'b1;
      hresp_r     <= 1'b0;
      tx_prev_r   <= 1'b0;
      rx_prev_r   <= 1'b0;
      mask_dly_r  <= 3'h0;
      txp_r       <= 1'b0;
      txn_r       <= 1'b0;
      rxd_r       <= 1'b0;
      rxn_r       <= 1'b0;
      rval_r      <= 1'b0;
    end else begin
      cfg_r       <= cfg_nxt;
      viol_r      <= viol_nxt;
      bst_r       <= bst_nxt;
      addr_r      <= addr_nxt;
      o_hrdata    <= rdata_nxt;
      hrdy_r      <= 1'b1;
      hresp_r     <= 1'b0;
      tx_prev_r   <= tx_ref;
      rx_prev_r   <= rx_ref;
      mask_dly_r  <= mask_dly_nxt;
      txp_r       <= txp_nxt;
      txn_r       <= txn_nxt;
      rxd_r       <= rxd_nxt;
      rxn_r       <= rxn_nxt;
      rval_r      <= rval_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign o_tx_pos_rail    = txp_r;
  assign o_tx_neg_rail    = txn_r;
  assign o_rx_serial_data = rxd_r;
  assign o_rx_neg_data    = rxn_r;
  assign o_rx_data_valid  = rval_r;
  assign o_hreadyout      = hrdy_r;
  assign o_hresp          = hresp_r;

  // Transmit rail checks
  tx_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !$past(tx_edge) |-> $stable(o_tx_neg_rail))
    else $error("Transmit negative rail changed without a reference edge");
  neg_rail_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (tx_edge && !cfg_r.overhead_mask_mode && !cfg_r.unipolar_mode && !cfg_r.tx_pol
     && $stable(cfg_r)) |=> (o_tx_neg_rail == $past(s_tx_neg)))
    else $error("Negative rail does not follow bipolar data");
  // Mask output is the third stage, read before the shift
  mask_delay_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (tx_edge && cfg_r.overhead_mask_mode && $stable(cfg_r))
      |=> (o_tx_neg_rail == ($past(mask_dly_r[2]) ^ cfg_r.tx_pol)))
    else $error("Mask output is not the third delayed mask");
  // Loopback feeds the receive mask into the delay line
  loop_mask_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (tx_edge && cfg_r.loopback && $stable(cfg_r)) |=> (mask_dly_r[0] == $past(s_rx_neg)))
    else $error("Loopback mask not taken from receive side");
  tx_pol_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (tx_edge && $stable(cfg_r)) |=> (o_tx_pos_rail == ($past(s_tx_data) ^ cfg_r.tx_pol)))
    else $error("Transmit data polarity wrong");
  // Unused negative rail rests at its polarity level
  idle_neg_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (tx_edge && cfg_r.unipolar_mode && !cfg_r.overhead_mask_mode && $stable(cfg_r))
      |=> (o_tx_neg_rail == cfg_r.tx_pol))
    else $error("Idle negative rail not at its rest level");
  // Reference selection; a change of selection may fake one edge, so skip it
  tx_edge_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (!cfg_r.tx_inv && cfg_r.tx_sel == `TX_SEL_LINE_OUT && $rose(s_tx_line_clk)
     && $stable(cfg_r)) |-> tx_edge)
    else $error("Default transmit reference edge missed");
  tx_ref_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (!cfg_r.tx_inv && cfg_r.tx_sel == `TX_SEL_RX_OUT && $rose(s_rx_clk_out)
     && $stable(cfg_r)) |-> tx_edge)
    else $error("Selected transmit reference edge missed");
  rx_edge_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (!cfg_r.rx_inv && cfg_r.rx_sel == `RX_SEL_LINE && $rose(s_rx_line_clk)
     && $stable(cfg_r)) |-> rx_edge)
    else $error("Receive line clock edge missed");
  // Receive sampling checks
  rx_sample_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (rx_edge && !cfg_r.rx_pol && $stable(cfg_r)) |=> (o_rx_serial_data == $past(s_rx_pos)))
    else $error("Receive data not sampled on edge");
  rx_neg_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (rx_edge && !cfg_r.unipolar_mode && !cfg_r.overhead_mask_mode && $stable(cfg_r))
      |=> (o_rx_neg_data == ($past(s_rx_neg) ^ cfg_r.rx_pol)))
    else $error("Receive negative data not sampled on edge");
  rx_ovh_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (rx_edge && cfg_r.overhead_mask_mode && (s_rx_neg ^ cfg_r.rx_pol)) |=> !o_rx_data_valid)
    else $error("Overhead bit marked valid");
  rx_valid_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (rx_edge && !cfg_r.overhead_mask_mode) |=> o_rx_data_valid)
    else $error("Payload bit not marked valid");
  rx_idle_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !rx_edge |=> !o_rx_data_valid)
    else $error("Receive valid without a reference edge");
  // Violation counter steps only on a sampled violation
  viol_cnt_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (rx_edge && cfg_r.unipolar_mode && !cfg_r.overhead_mask_mode && (s_rx_neg ^ cfg_r.rx_pol))
      |=> (viol_r == $past(viol_r) + VIOL_W'(`VIOL_INC)))
    else $error("Violation counter did not step");
  viol_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !rx_edge |=> (viol_r == $past(viol_r)))
    else $error("Violation counter moved without an edge");
  // Configuration lands at the end of its write data phase
  cfg_write_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (bst_r == line_pin_pkg::BUS_WRITE && addr_r == `ADDR_CFG)
      |=> (cfg_r == $past(i_hwdata[`CFG_MSB_TXSEL:0])))
    else $error("Configuration write did not land");

endmodule // line_pin_if

// File: verification/line_far_end.sv
// Far-end line interface model: receive line clock and receive rails.
// Assumes the bench raises i_en for a frame and drops it after a rise.
`timescale 1ns/1ns
module line_far_end (
  input  wire logic i_en,
  input  wire logic i_pos,
  input  wire logic i_neg,
  output logic      o_clk,
  output logic      o_pos,
  output logic      o_neg
);
  initial begin
    o_clk = 1'b0;
    o_pos = 1'b0;
    o_neg = 1'b0;
  end
  // One bit a period; rails move at the fall so they are settled at the rise
  always begin
    wait (i_en === 1'b1);
    #1;
    while (i_en === 1'b1) begin
      o_clk = 1'b0;
      o_pos = i_pos;
      o_neg = i_neg;
      #62;
      o_clk = 1'b1;
      #63;
    end
    // Clock stands low between frames; released rails must not look stale
    o_clk = 1'b0;
    o_pos = ~o_pos;
    o_neg = ~o_neg;
  end
endmodule // line_far_end

// File: verification/tb.sv
// Self-checking bench for one line pin port: bus, transmit and receive bits.
// Assumes the far-end model supplies the line clock used as every reference.
`timescale 1ns/1ns
`include "line_pin_map.svh"
module tb;
  logic        i_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic        hsel = 1'b1, hwrite = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0, hrdata, rd_val, seed = 32'h00002F1E;
  logic        hready, lclk, far_pos, far_neg, far_en = 1'b0;
  logic        tx_data = 1'b0, tx_neg = 1'b0, tx_mask = 1'b0, rx_pos, rx_neg;
  logic        tx_pos_o, tx_neg_o, rx_data_o, rx_neg_o, valid_o, hresp;
  logic        p_pos = 1'b0, p_neg = 1'b0;
  logic [3:0]  hist = 4'h0;
  logic [15:0] viol_cnt = 16'h0000;
  logic [9:0]  line_q[$];
  logic [31:0] rd_q[$];
  logic [10:0] cfgs[11] = '{11'h000, 11'h020, 11'h001, 11'h002, 11'h022, 11'h300, 11'h021,
                            11'h006, 11'h040, 11'h041, 11'h4A0};
  int          fail_count = 0, n_tests = 0, vcnt = 0, vlast = 0;
  event        rd_ev;
  always #5 i_clk = ~i_clk;
  line_far_end i_far (.i_en(far_en), .i_pos(p_pos), .i_neg(p_neg),
    .o_clk(lclk), .o_pos(rx_pos), .o_neg(rx_neg));
  line_pin_if #(.VIOL_W(16)) i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
    .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready),
    .o_hresp(hresp), .i_tx_line_clock_out(lclk), .i_tx_clock_out(lclk),
    .i_tx_clock_in(lclk), .i_rx_line_clock(lclk), .i_rx_clock_out(lclk),
    .i_tx_serial_data(tx_data), .i_tx_neg_data(tx_neg), .i_tx_overhead_mask_in(tx_mask),
    .o_tx_pos_rail(tx_pos_o), .o_tx_neg_rail(tx_neg_o), .i_rx_pos_rail(rx_pos),
    .i_rx_neg_rail(rx_neg), .o_rx_serial_data(rx_data_o), .o_rx_neg_data(rx_neg_o),
    .o_rx_data_valid(valid_o));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Single AHB-Lite transfer; waits on hready rather than assuming zero wait
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int t;
    @(posedge i_clk);
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    t = 0;
    do begin @(posedge i_clk); t++; end while (hready !== 1'b1 && t < 50);
    htrans <= 2'h0;
    hwdata <= d;
    do begin @(posedge i_clk); t++; end while (hready !== 1'b1 && t < 100);
    if (t >= 100) fail_count++;
    check({31'h0, hresp}, 32'h0);
    if (!wr) begin
      rd_val = hrdata;
      ->rd_ev;
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    rd_q.push_back(exp);
    bus(1'b0, a, 32'h0);
  endtask
  // Twelve random bits in one frame; expectations follow the configured mode
  task automatic frame(input logic [10:0] cfg);
    logic [31:0] r;
    logic [4:0]  e, c;
    for (int k = 0; k < 12; k++) begin
      @(posedge i_clk);
      r = xs();
      tx_data <= r[0];
      tx_neg  <= r[1];
      tx_mask <= r[2];
      p_pos   <= r[3];
      p_neg   <= r[4];
      far_en  <= 1'b1;
      hist = {hist[2:0], cfg[2] ? r[4] : r[2]};
      e[4] = r[0] ^ cfg[5];
      c[4] = 1'b1;
      e[3] = cfg[5] ^ (cfg[1] ? hist[3] : (cfg[0] ? 1'b0 : r[1]));
      c[3] = !(cfg[1] && k < 3);
      e[2] = r[3] ^ cfg[6];
      e[1] = (cfg[0] | cfg[1]) ? 1'b0 : (r[4] ^ cfg[6]);
      e[0] = cfg[1] ? !(r[4] ^ cfg[6]) : 1'b1;
      c[2:0] = 3'h7;
      if (cfg[0] && !cfg[1] && (r[4] ^ cfg[6])) viol_cnt++;
      line_q.push_back({c, e});
      @(posedge lclk);
    end
    @(posedge i_clk);
    far_en <= 1'b0;
    #100;
  endtask
  // Valid pulses counted so each bit can be tied to exactly one pulse
  always @(posedge i_clk) if (valid_o === 1'b1) vcnt++;
  // Line monitor: outputs are settled well before the next falling edge
  always begin
    logic [9:0] q;
    @(posedge lclk);
    #55;
    q = line_q.pop_front();
    check({tx_pos_o, tx_neg_o, rx_data_o, rx_neg_o, (vcnt - vlast) == 1} & q[9:5],
          q[4:0] & q[9:5]);
    vlast = vcnt;
  end
  // Read monitor
  always begin
    @(rd_ev);
    check(rd_val, rd_q.pop_front());
  end
  initial begin
    #300000;
    fail_count++;
    end_of_test;
  end
  initial begin
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b0;
    rd(`ADDR_CFG, 32'h0);
    rd(12'h00C, 32'h0);
    foreach (cfgs[i]) begin
      bus(1'b1, `ADDR_CFG, {21'h0, cfgs[i]});
      frame(cfgs[i]);
      rd(`ADDR_CFG, {21'h0, cfgs[i]});
      rd(`ADDR_VIOL, {16'h0, viol_cnt});
      rd(`ADDR_STAT, {29'h0, 2'b00, hist[2]});
    end
    bus(1'b1, 12'h00C, 32'hFFFFFFFF);
    rd(`ADDR_CFG, {21'h0, cfgs[10]});
    end_of_test;
  end
endmodule // tb
